// >>> core/sysclk_ctrl_pkg.sv
// Package with register map, field layout, encodings and timing for the system clock control block.
package sysclk_ctrl_pkg;

  localparam int AddrWidth = 8;
  localparam logic [7:0] OffsPowerMgmt = 8'h00;
  localparam logic [7:0] OffsExtIntFlag = 8'h04;
  localparam logic [7:0] OffsBusMode = 8'h08;
  localparam logic [7:0] OffsIrqStatus = 8'h0c;
  localparam logic [7:0] OffsIrqClear = 8'h10;
  localparam logic [7:0] OffsIrqEnable = 8'h14;

  // Power management register fields.
  localparam int PosDivSelLo = 6;
  localparam int PosSwitchback = 5;
  localparam int PosMulEnable = 4;
  localparam int PosMulFactor = 3;
  // Extended interrupt flag register fields.
  localparam int PosMulReady = 3;
  localparam int PosRingMode = 2;

  localparam logic [1:0] DivSelMul = 2'h0;
  localparam logic [1:0] DivSelRsvd = 2'h1;
  localparam logic [1:0] DivSelOne = 2'h2;
  localparam logic [1:0] DivSelSlow = 2'h3;

  localparam logic [1:0] BusModeInternal = 2'h0;
  localparam logic [1:0] BusModeOne = 2'h1;
  localparam logic [1:0] BusModeTwo = 2'h2;
  localparam logic [1:0] BusModeFour = 2'h3;

  localparam int IrqCount = 3;
  localparam int IrqReady = 0;
  localparam int IrqSwitchback = 1;
  localparam int IrqRefused = 2;

  localparam int WarmupExtCycles = 65536;
  localparam int SlowDivide = 1024;

  typedef struct packed {
    logic [1:0] divSel;
    logic switchbackEnable;
    logic mulEnable;
    logic mulFactor4x;
  } clk_cfg_s;

  typedef struct packed {
    logic sysClkEn;
    logic memCycleEn;
    logic mulActive;
  } clk_out_s;

endpackage

// >>> core/system_clock_divide_control.sv
// System clock divide, multiplier warm-up, switchback and memory cycle timing with APB registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module system_clock_divide_control #(
  parameter int WarmupCycles = 65536
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sysclk_ctrl_pkg::AddrWidth-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Wake sources and status from the core.
  input wire logic enabledIrq,
  input wire logic serialStartBit,
  input wire logic ringOscMode,
  // Clock enables toward the core.
  output sysclk_ctrl_pkg::clk_out_s clkOut,
  // Interrupt.
  output logic irq
);
  import sysclk_ctrl_pkg::*;

  typedef enum logic [1:0] {
    MulOff = 2'b00,
    MulWarm = 2'b01,
    MulReady = 2'b10
  } mul_state_e;

  // The wake inputs come from other domains or pins, so two flops guard them.
  logic [1:0] irqSync;
  logic [1:0] startSync;
  logic [1:0] ringSync;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqSync <= 2'h0;
      startSync <= 2'h0;
      ringSync <= 2'h0;
    end else begin
      irqSync <= {irqSync[0], enabledIrq};
      startSync <= {startSync[0], serialStartBit};
      ringSync <= {ringSync[0], ringOscMode};
    end
  end
  logic wakeEvent;
  logic ringMode;
  assign wakeEvent = irqSync[1] | startSync[1];
  assign ringMode = ringSync[1];

  ////////////////////////////////////////////////////////////////////////////////
  logic setupPhase;
  logic wrAccess;
  logic rdAccess;
  assign setupPhase = psel & ~penable;
  assign wrAccess = psel & penable & pwrite;
  assign rdAccess = psel & penable & ~pwrite;
  assign pready = 1'b1;

  function automatic logic addrMapped(input logic [AddrWidth-1:0] a);
    return a == OffsPowerMgmt || a == OffsExtIntFlag || a == OffsBusMode ||
           a == OffsIrqStatus || a == OffsIrqClear || a == OffsIrqEnable;
  endfunction

  assign pslverr = psel & penable & ~addrMapped(paddr);

  clk_cfg_s cfg_reg, cfg_next;
  mul_state_e mulState_reg, mulState_next;
  logic [16:0] warmCnt_reg, warmCnt_next;
  logic [1:0] busMode_reg, busMode_next;
  logic [IrqCount-1:0] irqStatus_reg, irqStatus_next;
  logic [IrqCount-1:0] irqEnable_reg, irqEnable_next;
  logic [31:0] prdata_reg, prdata_next;
  logic refusedEvt;
  logic switchEvt;
  logic memBoundary;

  always_comb begin
    logic [1:0] wrSel;
    wrSel = pwdata[PosDivSelLo +: 2];
    cfg_next = cfg_reg;
    mulState_next = mulState_reg;
    warmCnt_next = warmCnt_reg;
    refusedEvt = 1'b0;
    switchEvt = 1'b0;
    if (wrAccess && paddr == OffsPowerMgmt) begin
      cfg_next.switchbackEnable = pwdata[PosSwitchback];
      if (cfg_reg.divSel == DivSelOne && !cfg_reg.mulEnable) begin
        cfg_next.mulFactor4x = pwdata[PosMulFactor];
      end else if (pwdata[PosMulFactor] != cfg_reg.mulFactor4x) begin
        refusedEvt = 1'b1;
      end
      if (cfg_reg.divSel == DivSelOne && !ringMode) begin
        cfg_next.mulEnable = pwdata[PosMulEnable];
      end else if (pwdata[PosMulEnable] != cfg_reg.mulEnable) begin
        refusedEvt = 1'b1;
      end
      if (wrSel == DivSelRsvd) begin
        refusedEvt = 1'b1;
      end else if (wrSel == DivSelMul && mulState_reg != MulReady) begin
        refusedEvt = 1'b1;
      end else begin
        cfg_next.divSel = wrSel;
      end
    end
    // Leaving the multiplier ready state while it drives the clock would stall the core.
    if (!cfg_next.mulEnable && cfg_next.divSel == DivSelMul) begin
      cfg_next.divSel = DivSelOne;
    end
    if (cfg_reg.divSel == DivSelSlow && cfg_reg.switchbackEnable && wakeEvent) begin
      cfg_next.divSel = DivSelOne;
      switchEvt = 1'b1;
    end
    unique case (mulState_reg)
      MulOff: begin
        if (cfg_next.mulEnable && !cfg_reg.mulEnable) begin
          mulState_next = MulWarm;
          warmCnt_next = '0;
        end
      end
      MulWarm: begin
        warmCnt_next = warmCnt_reg + 17'h1;
        if (!cfg_next.mulEnable) begin
          mulState_next = MulOff;
        end else if (warmCnt_reg == 17'(WarmupCycles - 1)) begin
          mulState_next = MulReady;
        end
      end
      MulReady: begin
        if (!cfg_next.mulEnable) begin
          mulState_next = MulOff;
        end
      end
      default: mulState_next = MulOff;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_reg <= '{divSel: DivSelOne, switchbackEnable: 1'b0, mulEnable: 1'b0, mulFactor4x: 1'b0};
      mulState_reg <= MulOff;
      warmCnt_reg <= 17'h0;
    end else begin
      cfg_reg <= cfg_next;
      mulState_reg <= mulState_next;
      warmCnt_reg <= warmCnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Only a change of the divide field to the multiplier waits for a memory cycle boundary; other codes reach the clock path at once.
  logic [1:0] activeSel_reg, activeSel_next;
  logic [9:0] slowCnt_reg, slowCnt_next;
  logic [1:0] memCnt_reg, memCnt_next;
  logic sysEn;
  logic [1:0] memLen;

  always_comb begin
    activeSel_next = activeSel_reg;
    if (memBoundary || cfg_reg.divSel != DivSelMul) begin
      activeSel_next = cfg_reg.divSel;
    end
    // The ref_clk stands in for the multiplied and divide-by-one clocks; only the slow rate is an enable pulse.
    slowCnt_next = (activeSel_reg == DivSelSlow) ? slowCnt_reg + 10'h1 : 10'h0;
    unique case (busMode_reg)
      BusModeInternal: memLen = 2'h0;
      BusModeOne: memLen = 2'h0;
      BusModeTwo: memLen = 2'h1;
      default: memLen = 2'h3;
    endcase
    memCnt_next = memCnt_reg;
    if (sysEn) begin
      memCnt_next = (memCnt_reg >= memLen) ? 2'h0 : memCnt_reg + 2'h1;
    end
  end

  assign sysEn = (activeSel_reg == DivSelSlow) ? (slowCnt_reg == 10'(SlowDivide - 1)) : 1'b1;
  assign memBoundary = sysEn && memCnt_reg >= memLen;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      activeSel_reg <= DivSelOne;
      slowCnt_reg <= 10'h0;
      memCnt_reg <= 2'h0;
    end else begin
      activeSel_reg <= activeSel_next;
      slowCnt_reg <= slowCnt_next;
      memCnt_reg <= memCnt_next;
    end
  end

  assign clkOut = '{sysClkEn: sysEn, memCycleEn: memBoundary, mulActive: activeSel_reg == DivSelMul};

  ////////////////////////////////////////////////////////////////////////////////
  logic [IrqCount-1:0] events;
  assign events = {refusedEvt, switchEvt, mulState_reg == MulWarm && mulState_next == MulReady};

  always_comb begin
    busMode_next = busMode_reg;
    irqEnable_next = irqEnable_reg;
    irqStatus_next = irqStatus_reg;
    if (wrAccess && paddr == OffsBusMode) begin
      busMode_next = pwdata[1:0];
    end
    if (wrAccess && paddr == OffsIrqEnable) begin
      irqEnable_next = pwdata[IrqCount-1:0];
    end
    if (wrAccess && paddr == OffsIrqClear) begin
      irqStatus_next = irqStatus_next & ~pwdata[IrqCount-1:0];
    end
    // A new event wins over a clear in the same cycle.
    irqStatus_next = irqStatus_next | events;
    prdata_next = prdata_reg;
    if (setupPhase && !pwrite) begin
      unique case (paddr)
        OffsPowerMgmt: prdata_next = {24'h0, cfg_reg.divSel, cfg_reg.switchbackEnable, cfg_reg.mulEnable,
                                      cfg_reg.mulFactor4x, 3'h0};
        OffsExtIntFlag: prdata_next = {28'h0, mulState_reg == MulReady, ringMode, 2'h0};
        OffsBusMode: prdata_next = {30'h0, busMode_reg};
        OffsIrqStatus: prdata_next = {29'h0, irqStatus_reg};
        OffsIrqEnable: prdata_next = {29'h0, irqEnable_reg};
        default: prdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busMode_reg <= BusModeInternal;
      irqEnable_reg <= '0;
      irqStatus_reg <= '0;
      prdata_reg <= 32'h0;
    end else begin
      busMode_reg <= busMode_next;
      irqEnable_reg <= irqEnable_next;
      irqStatus_reg <= irqStatus_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = rdAccess ? prdata_reg : 32'h0;
  assign irq = |(irqStatus_reg & irqEnable_reg);

  ////////////////////////////////////////////////////////////////////////////////
  property p_divsel_legal;
    @(posedge ref_clk) disable iff (srst) cfg_reg.divSel != DivSelRsvd;
  endproperty
  a_divsel_legal: assert property (p_divsel_legal) else $error("Reserved divide code stored.");

  property p_no_mul_unready;
    @(posedge ref_clk) disable iff (srst) cfg_reg.divSel == DivSelMul |-> mulState_reg == MulReady;
  endproperty
  a_no_mul_unready: assert property (p_no_mul_unready) else $error("Multiplier selected before ready.");

  property p_factor_hold;
    @(posedge ref_clk) disable iff (srst)
      (cfg_reg.divSel != DivSelOne || cfg_reg.mulEnable) |=> $stable(cfg_reg.mulFactor4x);
  endproperty
  a_factor_hold: assert property (p_factor_hold) else $error("Factor changed while locked.");

  property p_enable_hold;
    @(posedge ref_clk) disable iff (srst)
      (cfg_reg.divSel != DivSelOne || ringMode) |=> $stable(cfg_reg.mulEnable);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("Enable changed while locked.");

  property p_warm_start;
    @(posedge ref_clk) disable iff (srst) $rose(cfg_reg.mulEnable) |-> mulState_reg == MulWarm && warmCnt_reg == 0;
  endproperty
  a_warm_start: assert property (p_warm_start) else $error("Warm-up did not start.");

  property p_ready_time;
    @(posedge ref_clk) disable iff (srst)
      $rose(mulState_reg == MulReady) |-> $past(warmCnt_reg) == 17'(WarmupCycles - 1);
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("Warm-up length wrong.");

  property p_switchback;
    @(posedge ref_clk) disable iff (srst)
      cfg_reg.divSel == DivSelSlow && cfg_reg.switchbackEnable && wakeEvent |=> cfg_reg.divSel == DivSelOne;
  endproperty
  a_switchback: assert property (p_switchback) else $error("Switchback missing.");

  property p_no_switch_other;
    @(posedge ref_clk) disable iff (srst)
      cfg_reg.divSel != DivSelSlow && !(wrAccess && paddr == OffsPowerMgmt) |=> $stable(cfg_reg.divSel);
  endproperty
  a_no_switch_other: assert property (p_no_switch_other) else $error("Divide changed without write.");

  property p_internal_mem;
    @(posedge ref_clk) disable iff (srst)
      busMode_reg == BusModeInternal && sysEn |-> memBoundary;
  endproperty
  a_internal_mem: assert property (p_internal_mem) else $error("Internal memory cycle not one clock.");

  c_ready: cover property (@(posedge ref_clk) disable iff (srst) $rose(mulState_reg == MulReady));
  c_switch: cover property (@(posedge ref_clk) disable iff (srst) switchEvt);
  c_mul_active: cover property (@(posedge ref_clk) disable iff (srst) $rose(clkOut.mulActive));
  c_refused: cover property (@(posedge ref_clk) disable iff (srst) refusedEvt);

endmodule

// >>> tb/ext_osc_model.sv
// Model of the external oscillator that feeds the clock control block.
`timescale 1ns/1ps
module ext_osc_model #(
  parameter realtime HalfPeriod = 2.5
) (
  // Clock toward the device.
  output logic extClk
);
  // A clean oscillator runs free at a 50 percent duty cycle.
  initial extClk = 1'b0;
  always #(HalfPeriod) extClk = ~extClk;
endmodule

// >>> tb/testbench.sv
// Self-checking testbench for the system clock divide control block.
`timescale 1ns/1ps
module testbench;
  import sysclk_ctrl_pkg::*;
  localparam int Wu = 32;
  logic ref_clk;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic enabledIrq = 1'b0;
  logic serialStartBit = 1'b0;
  logic ringOscMode = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  clk_out_s clkOut;
  logic [31:0] rd;
  logic err;
  int failCount;
  int numChecks;
  int cycles;
  ////////////////////////////////////////////////////////////////////////////////
  ext_osc_model u_ext_osc_model (.extClk(ref_clk));
  system_clock_divide_control #(.WarmupCycles(Wu)) u_system_clock_divide_control (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enabledIrq(enabledIrq), .serialStartBit(serialStartBit), .ringOscMode(ringOscMode),
    .clkOut(clkOut), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdPm(input logic [31:0] exp);
    apb(1'b0, OffsPowerMgmt, 32'h0);
    chk(rd, exp);
  endtask
  // Counts how often an enable is seen high over a window of cycles.
  task automatic countEn(input int n, input int sel, output int c);
    c = 0;
    repeat (n) begin
      @(posedge ref_clk);
      c += (sel == 0) ? int'(clkOut.sysClkEn === 1'b1) : int'(clkOut.memCycleEn === 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic resetValues;
    rdPm(32'h80);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic mulSelect;
    int n;
    ringOscMode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(1'b1, OffsPowerMgmt, 32'h90);
    rdPm(32'h80);
    ringOscMode <= 1'b0;
    repeat (4) @(posedge ref_clk);
    apb(1'b1, OffsPowerMgmt, 32'h88);
    apb(1'b1, OffsPowerMgmt, 32'h98);
    apb(1'b1, OffsPowerMgmt, 32'h90);
    rdPm(32'h98);
    apb(1'b1, OffsPowerMgmt, 32'h18);
    rdPm(32'h98);
    apb(1'b0, OffsExtIntFlag, 32'h0);
    chk({31'h0, rd[PosMulReady]}, 32'h0);
    n = 0;
    do begin
      apb(1'b0, OffsExtIntFlag, 32'h0);
      n++;
    end while (rd[PosMulReady] !== 1'b1 && n < 20);
    chk({31'h0, rd[PosMulReady]}, 32'h1);
    chk(n, 7);
    chk({31'h0, clkOut.mulActive}, 32'h0);
    apb(1'b1, OffsPowerMgmt, 32'h18);
    n = 0;
    while (clkOut.mulActive !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, clkOut.mulActive}, 32'h1);
    chk(n, 1);
    rdPm(32'h18);
    apb(1'b1, OffsPowerMgmt, 32'h98);
    apb(1'b1, OffsPowerMgmt, 32'h88);
    rdPm(32'h88);
  endtask
  task automatic irqTest;
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, OffsIrqStatus, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h5);
    apb(1'b1, OffsIrqEnable, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OffsIrqClear, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OffsIrqClear, 32'h4);
    apb(1'b0, OffsIrqStatus, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h0);
    apb(1'b1, OffsIrqEnable, 32'h2);
  endtask
  task automatic slowMode;
    int c;
    apb(1'b1, OffsPowerMgmt, 32'hc8);
    countEn(2 * SlowDivide, 0, c);
    chk(c, 32'h2);
    enabledIrq <= 1'b1;
    repeat (8) @(posedge ref_clk);
    enabledIrq <= 1'b0;
    rdPm(32'hc8);
    apb(1'b1, OffsPowerMgmt, 32'he8);
    serialStartBit <= 1'b1;
    repeat (8) @(posedge ref_clk);
    serialStartBit <= 1'b0;
    chk({31'h0, irq}, 32'h1);
    rdPm(32'ha8);
    enabledIrq <= 1'b1;
    repeat (8) @(posedge ref_clk);
    enabledIrq <= 1'b0;
    rdPm(32'ha8);
    apb(1'b1, OffsPowerMgmt, 32'h68);
    rdPm(32'ha8);
    apb(1'b1, OffsIrqClear, 32'h2);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic busModes;
    int c;
    int exp [4] = '{16, 16, 8, 4};
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OffsBusMode, m);
      repeat (8) @(posedge ref_clk);
      countEn(16, 1, c);
      chk(c, exp[m]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrapUp;
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // The ceiling sits well above the few thousand cycles the run needs.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      wrapUp();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    resetValues();
    mulSelect();
    irqTest();
    slowMode();
    busModes();
    wrapUp();
  end
endmodule
